// ==== core/fcl_loader.sv ====
// Fuse configuration loader: power-up load, checksum check, protected burn
`timescale 1ns/10ps
module fcl_loader #(
    parameter int unsigned READY_CYC  = fcl_pkg::READY_DELAY_CYC,
    parameter int unsigned UNLOCK_CYC = fcl_pkg::UNLOCK_DELAY_CYC,
    parameter int unsigned STEP_CYC   = fcl_pkg::STAGGER_CYC
) (
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst,
    // Supply monitors and enable pin
    input  wire logic                      vcc_above_2v,
    input  wire logic                      burn_supply_ok,
    input  wire logic                      enable_sync_input,
    // Host register access from the serial-bus slave
    input  wire fcl_pkg::fcl_host_req_type host_req,
    output logic                           host_ack,
    output logic [7:0]                     host_rdata,
    output logic                           host_wr_refused,
    // Fuse store macro
    output logic [3:0]                     fuse_rd_addr,
    input  wire logic [7:0]                fuse_rd_data,
    input  wire logic [1:0]                fuse_burn_count,
    output fcl_pkg::fcl_fuse_wr_type       fuse_wr,
    // Converter side
    output logic                           link_ready,
    output logic [95:0]                    cfg_live,
    output logic [3:0]                     chan_run,
    output logic                           burn_active
);
    import fcl_pkg::*;

    fcl_state_type      state_r, state_nxt;       // Sequencer
    logic [CNT_W-1:0]   cnt_r;                    // Delay counter
    logic [3:0]         idx_r;                    // Byte index
    logic [15:0]        cs_r;                     // Running checksum
    logic [7:0]         cs_lo_r;                  // Stored checksum low byte
    logic               use_fuse_r;               // Fuse data passed check
    logic               cserr_r;                  // Checksum error flag
    logic               loaded_r;                 // Power-up load done
    logic               burn_req_r;               // Burn request bit, write lock
    logic [3:0]         run_mask_r;               // Channels allowed to run
    logic [7:0]         cfg_r [NUM_CFG];          // Live control registers
    fcl_fuse_wr_type    fuse_wr_r;                // Registered fuse write
    logic               ack_r;                    // Host answer strobe
    logic [7:0]         rdata_r;                  // Host read data
    logic               refused_r;                // Write refused strobe

    // Fixed combining step: rotate left then add, same for burn and check
    function automatic logic [15:0] cs_step(input logic [15:0] cs, input logic [7:0] b);
        cs_step = {cs[14:0], cs[15]} + {8'h00, b}; // see RULE_15
    endfunction : cs_step

    // Decode of counters and host access
    wire cnt_ready   = (cnt_r == CNT_W'(READY_CYC - 1));
    wire cnt_unlock  = (cnt_r == CNT_W'(UNLOCK_CYC - 1));
    wire cnt_step    = (cnt_r == CNT_W'(STEP_CYC - 1));
    wire host_hit    = host_req.req & link_ready;
    wire host_is_cfg = ~host_req.addr[ADDR_FUSE_BIT] & (host_req.addr[3:0] <= LAST_CFG_IDX);
    // Fuse space ends at the checksum; above it reads zero, not macro noise
    wire host_is_fuse = host_req.addr[ADDR_FUSE_BIT] & (host_req.addr[3:0] <= CS_HI_IDX);
    wire wr_refuse   = host_hit & host_req.wr & burn_req_r;                        // see RULE_08
    wire wr_live     = host_hit & host_req.wr & ~burn_req_r & host_is_cfg;        // see RULE_06
    wire wr_burn     = host_hit & host_req.wr & ~burn_req_r & (host_req.addr == ADDR_CTRL)
                       & host_req.wdata[CTRL_BURN_BIT] & (state_r == S_READY);    // see RULE_08
    wire fuse_done   = (fuse_burn_count != 2'h0);                                  // see RULE_03
    wire burn_allow  = burn_supply_ok & (fuse_burn_count < MAX_BURNS);            // see RULE_05
    wire cs_match    = ({fuse_rd_data, cs_lo_r} == cs_r);                          // see RULE_13
    wire [7:0] ctrl_rd = {4'h0, fuse_burn_count, cserr_r, burn_req_r};
    wire [7:0] cfg_rd  = host_is_cfg ? cfg_r[host_req.addr[3:0]] : 8'h00;
    wire [7:0] rd_mux  = host_is_fuse ? fuse_rd_data :                              // see RULE_05
                         (host_req.addr == ADDR_CTRL) ? ctrl_rd : cfg_rd;
    wire loading     = (state_r == S_CHECK) | (state_r == S_LOAD);
    wire [7:0] load_byte = use_fuse_r ? fuse_rd_data : DEFAULT_CFG[idx_r*8 +: 8];  // see RULE_13
    wire [7:0] burn_byte = (idx_r == CS_LO_IDX) ? cs_r[7:0] :
                           (idx_r == CS_HI_IDX) ? cs_r[15:8] : cfg_r[idx_r];       // see RULE_10

    assign fuse_rd_addr = loading ? idx_r : host_req.addr[3:0];
    // Held low through check and load, so no host write is lost under the load
    assign link_ready   = (state_r != S_WAIT) & (state_r != S_DELAY) & ~loading;   // see RULE_01
    assign host_ack        = ack_r;
    assign host_rdata      = rdata_r;
    assign host_wr_refused = refused_r;
    assign fuse_wr      = fuse_wr_r;
    assign burn_active  = burn_req_r;

    // Live registers drive the converter parameters directly
    genvar g;
    generate
        for (g = 0; g < NUM_CFG; g++) begin : g_cfg
            assign cfg_live[g*8 +: 8] = cfg_r[g]; // see RULE_02
        end
    endgenerate

    // Next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            S_WAIT:    if (vcc_above_2v) state_nxt = S_DELAY;                      // see RULE_01
            S_DELAY:   if (!vcc_above_2v) state_nxt = S_WAIT;
                       else if (cnt_ready) state_nxt = S_CHECK;
            S_CHECK:   if (!fuse_done || idx_r == CS_HI_IDX) state_nxt = S_LOAD;   // see RULE_03
            S_LOAD:    if (idx_r == LAST_CFG_IDX) state_nxt = S_READY;
            S_READY:   if (wr_burn) state_nxt = S_SUPPLY;
            S_SUPPLY:  state_nxt = burn_allow ? S_BURN : S_READY;                  // see RULE_09
            S_BURN:    if (idx_r == CS_HI_IDX) state_nxt = S_HOLD;
            S_HOLD:    if (cnt_unlock) state_nxt = S_RESTART;                      // see RULE_11
            S_RESTART: if (cnt_step && run_mask_r[2:0] == 3'h7) state_nxt = S_READY;
            default:   state_nxt = S_WAIT;
        endcase
    end

    // Sequencer and delay counter, restarted on every state change
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= S_WAIT;
            cnt_r   <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            // Stagger counter also restarts after each channel step
            if (state_nxt != state_r || (state_r == S_RESTART && cnt_step))
                cnt_r <= '0;
            else
                cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    // Byte index and checksum walk, shared by check and burn
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            idx_r   <= 4'h0;
            cs_r    <= 16'h0000;
            cs_lo_r <= 8'h00;
        end
        else if (state_nxt != state_r)
        begin
            idx_r <= 4'h0;
            // Keep the sum when moving from burn to hold, for read-out
            if (state_nxt != S_HOLD)
                cs_r <= 16'h0000;
        end
        else if (state_r == S_CHECK || state_r == S_BURN || state_r == S_LOAD)
        begin
            idx_r <= idx_r + 4'h1;
            if (idx_r <= LAST_CFG_IDX && state_r != S_LOAD)
                cs_r <= cs_step(cs_r, (state_r == S_CHECK) ? fuse_rd_data : cfg_r[idx_r]); // see RULE_10
            if (state_r == S_CHECK && idx_r == CS_LO_IDX)
                cs_lo_r <= fuse_rd_data;
        end
    end

    // Check verdict, error flag and one-time load marker
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            use_fuse_r <= 1'b0;
            cserr_r    <= 1'b0;
            loaded_r   <= 1'b0;
        end
        else
        begin
            // Verdict taken on the high checksum byte
            if (state_r == S_CHECK && idx_r == CS_HI_IDX)
            begin
                use_fuse_r <= cs_match;                 // see RULE_13
                cserr_r    <= cserr_r | ~cs_match;      // see RULE_14
            end
            // Marker is cleared only by reset; it gates the channel enables, not the load path
            if (state_r == S_LOAD && idx_r == LAST_CFG_IDX)
                loaded_r <= 1'b1;                       // see RULE_04
        end
    end

    // Live registers: power-up load or host write
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < NUM_CFG; i++)
                cfg_r[i] <= DEFAULT_CFG[i*8 +: 8];
        end
        else if (state_r == S_LOAD)
            cfg_r[idx_r] <= load_byte;                  // see RULE_02
        else if (wr_live)
            cfg_r[host_req.addr[3:0]] <= host_req.wdata; // see RULE_06
    end

    // Burn request bit doubles as the write lock
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            burn_req_r <= 1'b0;
        else if (wr_burn)
            burn_req_r <= 1'b1;                         // see RULE_08
        else if (state_r == S_SUPPLY && !burn_allow)
            burn_req_r <= 1'b0;                         // see RULE_09
        else if (state_r == S_HOLD && cnt_unlock)
            burn_req_r <= 1'b0;                         // see RULE_11
    end

    // Fuse write strobe, registered so data and strobe move together
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            fuse_wr_r <= '0;
        else
        begin
            fuse_wr_r.wr   <= (state_r == S_BURN);
            fuse_wr_r.last <= (state_r == S_BURN) & (idx_r == CS_HI_IDX);
            fuse_wr_r.addr <= idx_r;
            fuse_wr_r.data <= burn_byte;
        end
    end

    // Channel run mask: cleared for the burn, refilled one per step
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            run_mask_r <= RUN_ALL;
        else if (state_r == S_BURN || state_r == S_HOLD)
            run_mask_r <= RUN_NONE;                     // see RULE_07
        else if (state_r == S_RESTART && cnt_step)
            run_mask_r <= {run_mask_r[2:0], 1'b1};      // see RULE_07
    end

    // Registered channel enables; pin only gates, never reloads
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            chan_run <= RUN_NONE;
        else
            chan_run <= run_mask_r & {4{enable_sync_input & loaded_r}};
    end

    // Host answer one cycle after the request
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ack_r     <= 1'b0;
            rdata_r   <= 8'h00;
            refused_r <= 1'b0;
        end
        else
        begin
            ack_r     <= host_hit;
            refused_r <= wr_refuse;
            if (host_hit && !host_req.wr)
                rdata_r <= rd_mux;                      // see RULE_08
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence burn_end_s;
        (state_r == S_HOLD) && cnt_unlock;
    endsequence

    sequence unlocked_restart_s;
        (state_r == S_RESTART) && !burn_req_r && (run_mask_r == RUN_NONE);
    endsequence

    // Start delay fully spent when the fuse check begins
    sequence delay_end_s;
        $past(state_r) == S_DELAY && $past(cnt_ready);
    endsequence

    // Last live register just loaded
    sequence load_end_s;
        $past(state_r) == S_LOAD && $past(idx_r) == LAST_CFG_IDX;
    endsequence

    ready_after_delay_a: assert property ($rose(state_r == S_CHECK) |-> delay_end_s) // see RULE_01
        else $error("interface ready without the start delay");
    ready_after_load_a: assert property ($rose(link_ready) |-> load_end_s) // see RULE_02
        else $error("interface ready before the load ended");
    limit_abort_a: assert property (state_r == S_SUPPLY && fuse_burn_count == MAX_BURNS |=> !burn_req_r) // see RULE_05
        else $error("burn started on a spent fuse store");
    lock_read_a: assert property (host_hit && !host_req.wr |=> ack_r && !refused_r) // see RULE_08
        else $error("host read not served");
    load_once_a: assert property (state_r == S_LOAD |-> !loaded_r) // see RULE_04
        else $error("fuse load repeated after power-up");
    load_gate_a: assert property (state_r == S_CHECK && !fuse_done |=> state_r == S_LOAD && !use_fuse_r) // see RULE_03
        else $error("unprogrammed fuses were loaded");
    load_copy_a: assert property (state_r == S_LOAD |=> cfg_r[$past(idx_r)] == $past(load_byte)) // see RULE_02
        else $error("live register missed its load byte");
    live_write_a: assert property (wr_live |=> cfg_live[$past(host_req.addr[3:0])*8 +: 8] == $past(host_req.wdata)) // see RULE_06
        else $error("host write did not reach live register");
    write_lock_a: assert property (wr_refuse |=> refused_r && ack_r && $stable(cfg_live)) // see RULE_08
        else $error("locked write changed a live register");
    supply_abort_a: assert property (state_r == S_SUPPLY && !burn_supply_ok |=> state_r == S_READY && !burn_req_r) // see RULE_09
        else $error("burn not abandoned on low supply");
    burn_limit_a: assert property (fuse_wr.wr |-> fuse_burn_count < MAX_BURNS) // see RULE_05
        else $error("fuse written beyond the burn limit");
    cs_store_a: assert property (fuse_wr.wr && fuse_wr.addr == CS_LO_IDX |-> fuse_wr.data == cs_r[7:0] ##1 fuse_wr.last && fuse_wr.data == cs_r[15:8]) // see RULE_10
        else $error("checksum not written after data");
    burn_off_a: assert property (state_r == S_HOLD |=> chan_run == RUN_NONE) // see RULE_07
        else $error("channel running during burn");
    unlock_a: assert property (burn_end_s |=> unlocked_restart_s) // see RULE_11
        else $error("burn bit not cleared at end of hold");
    cs_error_a: assert property (state_r == S_CHECK && idx_r == CS_HI_IDX && !cs_match |=> cserr_r && !use_fuse_r) // see RULE_14
        else $error("checksum error not flagged");
endmodule : fcl_loader

// ==== core/fcl_pkg.sv ====
// Constants and carrier types of the fuse configuration loader
// Functional notes
// RULE_01 - Interface live 100us after supply exceeds 2V
// RULE_02 - Power-up copies fuse bytes into live registers
// RULE_03 - Load only if supply good and fuses programmed
// RULE_04 - Enable pin toggling never reloads fuse data
// RULE_05 - Fuses readable, at most three burns ever
// RULE_06 - Host register writes act on converters immediately
// RULE_07 - Channels off during burn, restart one by one
// RULE_08 - Burn request bit locks writes, reads still served
// RULE_09 - Burn supply not above 5.1V aborts and unlocks
// RULE_10 - Burn stores 16-bit checksum beside the data
// RULE_11 - Request bit clears 100ms after burn, writes unlock
// RULE_12 - Host should read back and reburn on mismatch
// RULE_13 - Power-up checksum match loads fuses, else defaults
// RULE_14 - Checksum mismatch sets host-readable error flag
// RULE_15 - One fixed 16-bit combining function for both
package fcl_pkg;
    // Clock rate and documented times
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned READY_DELAY_US  = 100;
    localparam int unsigned READY_DELAY_CYC = READY_DELAY_US * CLK_MHZ;
    localparam int unsigned UNLOCK_DELAY_MS = 100;
    localparam int unsigned UNLOCK_DELAY_CYC = UNLOCK_DELAY_MS * 1000 * CLK_MHZ;
    localparam int unsigned STAGGER_US      = 200;
    localparam int unsigned STAGGER_CYC     = STAGGER_US * CLK_MHZ;
    localparam int unsigned CNT_W           = 25;
    // Register map of the host access port
    localparam int unsigned NUM_CFG         = 12;
    localparam logic [3:0]  LAST_CFG_IDX    = 4'hb;
    localparam logic [3:0]  CS_LO_IDX       = 4'hc;
    localparam logic [3:0]  CS_HI_IDX       = 4'hd;
    localparam logic [4:0]  ADDR_CTRL       = 5'h0c;
    localparam int unsigned ADDR_FUSE_BIT   = 4;
    localparam int unsigned CTRL_BURN_BIT   = 0;
    localparam int unsigned CTRL_CSERR_BIT  = 1;
    localparam int unsigned CTRL_CNT_LSB    = 2;
    localparam logic [1:0]  MAX_BURNS       = 2'h3;
    // Hard-coded defaults, byte 0 in the low bits
    localparam logic [95:0] DEFAULT_CFG     = 96'h2a_54_18_2a_54_18_2a_54_0c_2a_54_0c;
    localparam logic [3:0]  RUN_NONE        = 4'h0;
    localparam logic [3:0]  RUN_ALL         = 4'hf;

    // Sequencer states, Gray coded along the power-up and burn path
    typedef enum logic [3:0] {
        S_WAIT    = 4'h0,
        S_DELAY   = 4'h1,
        S_CHECK   = 4'h3,
        S_LOAD    = 4'h2,
        S_READY   = 4'h6,
        S_SUPPLY  = 4'h7,
        S_BURN    = 4'h5,
        S_HOLD    = 4'h4,
        S_RESTART = 4'hc
    } fcl_state_type;

    // Host register access request
    typedef struct packed {
        logic       req;
        logic       wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } fcl_host_req_type;

    // One byte written into the fuse store
    typedef struct packed {
        logic       wr;
        logic       last;
        logic [3:0] addr;
        logic [7:0] data;
    } fcl_fuse_wr_type;
endpackage : fcl_pkg

// ==== verif/fcl_fuse_model.sv ====
// Behavioural fuse store macro that faces the loader
`timescale 1ns/10ps
module fcl_fuse_model
(
    // Clock
    input  wire logic                     mclk,
    // Loader side
    input  wire logic [3:0]               fuse_rd_addr,
    output logic      [7:0]               fuse_rd_data,
    output logic      [1:0]               fuse_burn_count,
    input  wire fcl_pkg::fcl_fuse_wr_type fuse_wr
);
    import fcl_pkg::*;
    logic [7:0] mem [0:13]; // Data bytes, then checksum lo and hi
    logic [1:0] count_r;    // Burns done, survives rst like real fuses

    // Blank store, never burned
    initial
    begin
        foreach (mem[i])
            mem[i] = 8'h00;
        count_r = 2'h0;
    end

    // Past the last byte a pattern shows, not a stale byte
    assign fuse_rd_data    = (fuse_rd_addr < 4'he) ? mem[fuse_rd_addr] : 8'ha5;
    assign fuse_burn_count = count_r;

    // Plain always so the bench may preload or corrupt bytes
    always @(posedge mclk)
    begin
        if (fuse_wr.wr)
        begin
            mem[fuse_wr.addr] <= fuse_wr.data;
            if (fuse_wr.last)
                count_r <= count_r + 2'h1;
        end
    end
endmodule : fcl_fuse_model

// ==== verif/fuse_config_loader_tb.sv ====
// Self-checking bench for the fuse configuration loader
`timescale 1ns/10ps
module fuse_config_loader_tb;
    import fcl_pkg::*;
    localparam int unsigned RDY = 8;  // Short ready delay
    localparam int unsigned UNL = 16; // Short unlock hold
    localparam int unsigned STP = 4;  // Short restart stagger
    // Table row: op, address, data, expected byte
    typedef struct packed {
        logic       wr;
        logic [4:0] addr;
        logic [7:0] wd;
        logic [7:0] exp;
    } fcl_row_type;

    logic             mclk, rst, vcc_above_2v, burn_supply_ok, enable_sync_input;
    fcl_host_req_type host_req;
    logic             host_ack, host_wr_refused, link_ready, burn_active;
    logic [7:0]       host_rdata, fuse_rd_data, rd;
    logic [3:0]       fuse_rd_addr, chan_run, prev;
    logic [1:0]       fuse_burn_count;
    fcl_fuse_wr_type  fuse_wr;
    logic [95:0]      cfg_live, pat;
    logic             rf;
    int               err_total, checks, n, k;
    logic [3:0]       seq [4] = '{4'h1, 4'h3, 4'h7, 4'hf};
    fcl_row_type      rows [10] = '{
        '{1'b1, 5'h03, 8'h5a, 8'h5a}, '{1'b0, 5'h03, 8'h00, 8'h5a},
        '{1'b1, 5'h0b, 8'hc3, 8'hc3}, '{1'b0, 5'h0b, 8'h00, 8'hc3},
        '{1'b1, 5'h10, 8'hff, 8'h00}, '{1'b0, 5'h10, 8'h00, 8'h00},
        '{1'b1, 5'h0c, 8'hfe, 8'h00}, '{1'b0, 5'h0c, 8'h00, 8'h00},
        '{1'b0, 5'h1f, 8'h00, 8'h00}, '{1'b0, 5'h0e, 8'h00, 8'h00}};

    fcl_loader #(.READY_CYC(RDY), .UNLOCK_CYC(UNL), .STEP_CYC(STP)) i_fcl_loader (
        .mclk(mclk), .rst(rst), .vcc_above_2v(vcc_above_2v), .burn_supply_ok(burn_supply_ok),
        .enable_sync_input(enable_sync_input), .host_req(host_req), .host_ack(host_ack),
        .host_rdata(host_rdata), .host_wr_refused(host_wr_refused), .fuse_rd_addr(fuse_rd_addr),
        .fuse_rd_data(fuse_rd_data), .fuse_burn_count(fuse_burn_count), .fuse_wr(fuse_wr),
        .link_ready(link_ready), .cfg_live(cfg_live), .chan_run(chan_run), .burn_active(burn_active));
    fcl_fuse_model i_fcl_fuse_model (.mclk(mclk), .fuse_rd_addr(fuse_rd_addr),
        .fuse_rd_data(fuse_rd_data), .fuse_burn_count(fuse_burn_count), .fuse_wr(fuse_wr));

    // 250 MHz clock
    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    // Compare and count
    task check(input string what, input logic [95:0] seen, input logic [95:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Single closing point
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    // Bounded waits end here when they run out
    task timeout_if(input logic hit, input string what);
        if (!hit)
        begin
            err_total++;
            $display("Error %s timed out", what);
            report_and_stop();
        end
    endtask : timeout_if

    // Checksum worked out independently: rotate left, then add
    function automatic logic [15:0] cs_of(input logic [95:0] c);
        logic [15:0] cs;
        cs = 16'h0000;
        for (int i = 0; i < 12; i++)
            cs = {cs[14:0], cs[15]} + {8'h00, c[8*i +: 8]};
        return cs;
    endfunction : cs_of

    // One host access, held one cycle, answer one cycle later
    task host_op(input logic wr, input logic [4:0] addr, input logic [7:0] wd);
        @(posedge mclk);
        host_req <= '{req: 1'b1, wr: wr, addr: addr, wdata: wd};
        @(posedge mclk);
        host_req <= '0;
        #1;
        check("host_ack", host_ack, 1'b1);
        rd = host_rdata;
        rf = host_wr_refused;
    endtask : host_op

    // Reset, supply low a while, then supply good until ready
    task power_up;
        @(posedge mclk);
        rst          <= 1'b1;
        vcc_above_2v <= 1'b0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (20) @(posedge mclk);
        #1 check("early_ready", link_ready, 1'b0);
        @(posedge mclk);
        vcc_above_2v <= 1'b1;
        n = 0;
        while (link_ready !== 1'b1 && n < 200)
        begin
            @(posedge mclk);
            #1 n++;
        end
        timeout_if(link_ready === 1'b1, "link_ready");
        check("ready_delay", n >= RDY, 1'b1);
        check("ready_late", n <= RDY + 30, 1'b1);
    endtask : power_up

    initial
    begin
        err_total = 0;
        checks = 0;
        rst = 1'b1;
        vcc_above_2v = 1'b0;
        burn_supply_ok = 1'b0;
        enable_sync_input = 1'b0;
        host_req = '0;
        // Blank fuses, enable pin low: defaults, no error flag
        power_up();
        check("blank_cfg", cfg_live, DEFAULT_CFG);
        foreach (rows[i])
        begin
            host_op(rows[i].wr, rows[i].addr, rows[i].wd);
            check("refused", rf, 1'b0);
            if (rows[i].wr && rows[i].addr < 5'h0c)
                check("cfg_byte", cfg_live[8*rows[i].addr[3:0] +: 8], rows[i].exp);
            else if (!rows[i].wr)
                check("rdata", rd, rows[i].exp);
        end
        $display("test table done");
        // Burn with weak supply is abandoned and unlocks
        host_op(1'b1, 5'h0c, 8'h01);
        check("lock_set", burn_active, 1'b1);
        repeat (4) @(posedge mclk);
        #1 check("abort_unlock", burn_active, 1'b0);
        check("abort_count", fuse_burn_count, 2'h0);
        $display("test weak_supply done");
        // Full burn of a known pattern with channels running
        @(posedge mclk);
        enable_sync_input <= 1'b1;
        burn_supply_ok    <= 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            pat[8*i +: 8] = 8'(i * 37 + 5);
            host_op(1'b1, 5'(i), pat[8*i +: 8]);
        end
        n = 0;
        while (chan_run !== RUN_ALL && n < 50)
        begin
            @(posedge mclk);
            #1 n++;
        end
        timeout_if(chan_run === RUN_ALL, "chan_on");
        check("chan_on", chan_run, RUN_ALL);
        host_op(1'b1, 5'h0c, 8'h01);
        host_op(1'b1, 5'h00, 8'hee);
        check("wr_lock", rf, 1'b1);
        check("cfg_kept", cfg_live, pat);
        host_op(1'b0, 5'h0c, 8'h00);
        check("req_bit", rd[0], 1'b1);
        n = 0;
        while (fuse_burn_count !== 2'h1 && n < 100)
        begin
            @(posedge mclk);
            #1 n++;
        end
        timeout_if(fuse_burn_count === 2'h1, "burn_count");
        check("chan_off", chan_run, RUN_NONE);
        check("still_locked", burn_active, 1'b1);
        prev = RUN_NONE;
        k = 0;
        for (n = 0; n < 300 && prev !== RUN_ALL; n++)
        begin
            @(posedge mclk);
            #1;
            if (chan_run !== prev && k < 4)
            begin
                check("restart", chan_run, seq[k]);
                prev = chan_run;
                k++;
            end
        end
        timeout_if(prev === RUN_ALL, "restart");
        check("unlocked", burn_active, 1'b0);
        for (int i = 0; i < 12; i++)
            check("fuse_byte", i_fcl_fuse_model.mem[i], pat[8*i +: 8]);
        check("fuse_cs", {i_fcl_fuse_model.mem[13], i_fcl_fuse_model.mem[12]}, cs_of(pat));
        // Host reads the store back through the bus
        for (int i = 0; i < 12; i++)
        begin
            host_op(1'b0, 5'h10 + 5'(i), 8'h00);
            check("fuse_rd", rd, pat[8*i +: 8]);
        end
        host_op(1'b0, 5'h1c, 8'h00);
        check("cs_read", rd, cs_of(pat) & 16'h00ff);
        host_op(1'b1, 5'h00, 8'h77);
        check("wr_open", rf, 1'b0);
        $display("test burn done");
        // Enable pin cycling keeps the host value
        @(posedge mclk);
        enable_sync_input <= 1'b0;
        repeat (5) @(posedge mclk);
        #1 check("pin_off", chan_run, RUN_NONE);
        @(posedge mclk);
        enable_sync_input <= 1'b1;
        repeat (20) @(posedge mclk);
        #1 check("no_reload", cfg_live[7:0], 8'h77);
        check("pin_on", chan_run, RUN_ALL);
        $display("test enable_toggle done");
        // Fresh power-up loads the burned pattern
        power_up();
        check("fuse_load", cfg_live, pat);
        host_op(1'b0, 5'h0c, 8'h00);
        check("ctrl_ok", rd, 8'h04);
        // Corrupted byte falls back to defaults and flags it
        i_fcl_fuse_model.mem[5] = i_fcl_fuse_model.mem[5] ^ 8'h01;
        power_up();
        check("bad_cs_cfg", cfg_live, DEFAULT_CFG);
        host_op(1'b0, 5'h0c, 8'h00);
        check("cs_flag", rd, 8'h06);
        $display("test checksum done");
        // Store already burned three times refuses a fourth
        i_fcl_fuse_model.count_r = 2'h3;
        host_op(1'b1, 5'h0c, 8'h01);
        repeat (6) @(posedge mclk);
        #1 check("limit_unlock", burn_active, 1'b0);
        check("limit_count", fuse_burn_count, 2'h3);
        $display("test burn_limit done");
        report_and_stop();
    end
endmodule : fuse_config_loader_tb
